// ### logic/wsc_map.vh
// Purpose: constants for the waveform sequence configuration block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: offsets are word aligned
`ifndef WSC_MAP_VH
`define WSC_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define WSC_OFS_SELECT 8'h00
`define WSC_OFS_SEQ_FIRST 8'h04
`define WSC_OFS_SEQ_LAST 8'h08
`define WSC_OFS_CYCLES 8'h0C
`define WSC_OFS_SEQ_SEL 8'h10
`define WSC_OFS_PAR_SEL 8'h14
`define WSC_OFS_SEQ_DATA 8'h18
`define WSC_OFS_COMMAND 8'h1C
`define WSC_OFS_XY_SEL 8'h20
`define WSC_OFS_XY_DATA 8'h24
`define WSC_OFS_STATUS 8'h28
`define WSC_OFS_ERROR 8'h2C
`define WSC_OFS_RUN_INFO 8'h30
// ----------------------------------------
// generator type codes
// ----------------------------------------
`define WSC_TYPE_NONE 3'h0
`define WSC_TYPE_ARB_VOLT 3'h1
`define WSC_TYPE_ARB_AMP 3'h2
`define WSC_TYPE_XY_VOLT_VS_AMP 3'h3
`define WSC_TYPE_XY_AMP_VS_VOLT 3'h4
`define WSC_TYPE_XY_SOLAR 3'h5
// ----------------------------------------
// command bits
// ----------------------------------------
`define WSC_CMD_SUBMIT 0
`define WSC_CMD_RUN 1
`define WSC_CMD_STOP 2
`define WSC_CMD_XY_SUBMIT 3
`define WSC_CMD_ERR_POP 4
// ----------------------------------------
// error codes
// ----------------------------------------
`define WSC_ERR_RANGE 4'h1
`define WSC_ERR_XY_NOSEL 4'h2
`define WSC_ERR_AC_NO_DC 4'h3
`define WSC_ERR_SLOW_RATE 4'h4
`define WSC_ERR_NOT_ARB 4'h5
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define WSC_SEQ_MAX 7'd99
`define WSC_SEQ_RESET 7'd1
`define WSC_CYCLES_RESET 10'd1
// min relative rate 0.058 %/s in parts per million per second
`define WSC_MIN_REL_PPM 32'd580
// min frequency slew 9.3 Hz/s in tenths
`define WSC_MIN_FREQ_DHZ 32'd93
// sequence time unit in milliseconds per second
`define WSC_MS_PER_S 32'd1000
`endif

// ### logic/wsc_param_mem.v
// Purpose: dual port parameter storage, registered read data
// Assumes: single clock, one write port and one read port
// Notes: contents are volatile; not cleared by reset
`timescale 1ns/1ps
module wsc_param_mem #(
  parameter AW = 10,
  parameter DW = 32
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### logic/wsc_core.v
// Purpose: waveform sequence configuration and load logic behind AXI4-Lite
// Assumes: host writes registers in the documented loading order
// Notes: sequence values are 32-bit unsigned, amplitudes in ppm of nominal,
//   frequency in Hz, angle in degrees, time in milliseconds
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "wsc_map.vh"
module wsc_core #(
  parameter XY_DEPTH_LOG2 = 12
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire output_on,
  input wire alarm,
  input wire user_abort,
  input wire seq_done,
  input wire [2:0] act_par_sel,
  output wire [31:0] act_par_value,
  output reg arb_running,
  output reg xy_running,
  output reg [6:0] act_seq,
  output reg target_amp,
  output reg clip_negative,
  output reg [XY_DEPTH_LOG2-1:0] xy_wr_addr,
  output reg [31:0] xy_wr_data,
  output reg xy_wr_en,
  output reg xy_wr_is_amp,
  output reg xy_commit
);
  // ----------------------------------------
  // synchronise outside levels
  // ----------------------------------------
  reg [1:0] on_s;
  reg [1:0] alarm_s;
  reg [1:0] abort_s;
  always @(posedge clk) begin
    on_s <= {on_s[0], output_on};
    alarm_s <= {alarm_s[0], alarm};
    abort_s <= {abort_s[0], user_abort};
  end
  wire on_q = on_s[1];
  wire alarm_q = alarm_s[1];
  wire abort_q = abort_s[1];
  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] wdata_m = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}} & w_data;
  // ----------------------------------------
  // configuration state
  // ----------------------------------------
  reg [2:0] gen_type;
  reg [6:0] seq_first;
  reg [6:0] seq_last;
  reg [9:0] cycles;
  reg [6:0] seq_sel;
  reg [2:0] par_sel;
  reg [XY_DEPTH_LOG2-1:0] xy_sel;
  reg [99:0] bank_valid;
  reg [99:0] dc_start_set;
  reg [99:0] dc_end_set;
  reg [3:0] err_q [0:3];
  reg [2:0] err_cnt;
  reg [1:0] err_rd;
  reg [31:0] last_data;
  reg [9:0] cyc_done;
  wire is_arb = gen_type == `WSC_TYPE_ARB_VOLT || gen_type == `WSC_TYPE_ARB_AMP;
  // ----------------------------------------
  // shadow and active parameter arrays
  // ----------------------------------------
  reg sh_we;
  reg [31:0] sh_wdata;
  reg [9:0] sh_waddr;
  wire [31:0] sh_rdata;
  reg [6:0] copy_seq;
  reg [2:0] copy_par;
  reg copy_busy;
  reg copy_wr;
  reg [9:0] copy_waddr;
  wsc_param_mem #(.AW(10), .DW(32)) u_shadow (
    .clk(clk), .wr_en(sh_we), .wr_addr(sh_waddr), .wr_data(sh_wdata),
    .rd_addr({copy_seq, copy_par}), .rd_data(sh_rdata));
  wire [31:0] act_rdata;
  // active array, filled by submit copy
  wsc_param_mem #(.AW(10), .DW(32)) u_active (
    .clk(clk), .wr_en(copy_wr), .wr_addr(copy_waddr), .wr_data(sh_rdata),
    .rd_addr({act_seq, act_par_sel}), .rd_data(act_rdata));
  assign act_par_value = bank_valid[act_seq] ? act_rdata : 32'h0000_0000;
  // ----------------------------------------
  // acceptance check of a sequence value
  // ----------------------------------------
  reg [31:0] cmp_start;
  reg [31:0] cmp_time;
  reg [3:0] chk_err;
  reg [63:0] delta;
  reg [63:0] need;
  // keep start/end and time mirrors for the checks
  reg [31:0] mir [0:7];
  always @* begin
    chk_err = 4'h0;
    cmp_start = 32'h0000_0000;
    cmp_time = mir[7];
    delta = 64'h0000_0000_0000_0000;
    need = 64'h0000_0000_0000_0000;
    case (par_sel)
      3'd1: cmp_start = mir[0];
      3'd3: cmp_start = mir[2];
      3'd6: cmp_start = mir[5];
      default: cmp_start = wdata_m;
    endcase
    delta = (wdata_m > cmp_start) ? {32'h0000_0000, wdata_m - cmp_start} :
      {32'h0000_0000, cmp_start - wdata_m};
    if (par_sel == 3'd3) begin
      // frequency slew in tenths hz per second
      need = (`WSC_MIN_FREQ_DHZ * cmp_time) / 64'd10;
      if (delta * 64'd1000 * 64'd10 < need * 64'd10) begin
        chk_err = `WSC_ERR_SLOW_RATE;
      end
    end else begin
      // relative rate for amplitude and offset
      need = (`WSC_MIN_REL_PPM * cmp_time) / `WSC_MS_PER_S;
      if (delta != 64'd0 && delta < need) begin
        chk_err = `WSC_ERR_SLOW_RATE;
      end
    end
    if (delta == 64'd0) begin
      chk_err = 4'h0;
    end
    if (par_sel == 3'd0 && !dc_start_set[seq_sel]) begin
      chk_err = `WSC_ERR_AC_NO_DC;
    end
    if (par_sel == 3'd1 && !dc_end_set[seq_sel]) begin
      chk_err = `WSC_ERR_AC_NO_DC;
    end
    if (!is_arb) begin
      chk_err = `WSC_ERR_NOT_ARB;
    end
  end
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  reg push_err;
  reg [3:0] push_code;
  reg pop_err;
  reg run_cmd;
  reg stop_cmd;
  integer i;
  always @(posedge clk) begin
    sh_we <= 1'b0;
    xy_wr_en <= 1'b0;
    xy_commit <= 1'b0;
    push_err <= 1'b0;
    pop_err <= 1'b0;
    run_cmd <= 1'b0;
    stop_cmd <= 1'b0;
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      gen_type <= `WSC_TYPE_NONE;
      seq_first <= `WSC_SEQ_RESET;
      seq_last <= `WSC_SEQ_RESET;
      cycles <= `WSC_CYCLES_RESET;
      seq_sel <= `WSC_SEQ_RESET;
      par_sel <= 3'd0;
      xy_sel <= {XY_DEPTH_LOG2{1'b0}};
      dc_start_set <= 100'd0;
      dc_end_set <= 100'd0;
      last_data <= 32'h0000_0000;
      xy_wr_addr <= {XY_DEPTH_LOG2{1'b0}};
      xy_wr_data <= 32'h0000_0000;
      xy_wr_is_amp <= 1'b0;
      push_code <= 4'h0;
      sh_waddr <= 10'd0;
      sh_wdata <= 32'h0000_0000;
      for (i = 0; i < 8; i = i + 1) begin
        mir[i] <= 32'h0000_0000;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr)
          `WSC_OFS_SELECT: begin
            // only the listed types, power not offered
            if (wdata_m[2:0] <= `WSC_TYPE_XY_SOLAR) begin
              gen_type <= wdata_m[2:0];
            end else begin
              s_axi_bresp <= 2'b10;
            end
          end
          `WSC_OFS_SEQ_FIRST, `WSC_OFS_SEQ_LAST: begin
            if (wdata_m[6:0] >= 7'd1 && wdata_m[6:0] <= `WSC_SEQ_MAX &&
                wdata_m[31:7] == 25'd0) begin
              if (aw_addr == `WSC_OFS_SEQ_FIRST) seq_first <= wdata_m[6:0];
              else seq_last <= wdata_m[6:0];
            end else begin
              s_axi_bresp <= 2'b10;
              push_err <= 1'b1;
              push_code <= `WSC_ERR_RANGE;
            end
          end
          `WSC_OFS_CYCLES: cycles <= wdata_m[9:0];
          `WSC_OFS_SEQ_SEL: begin
            if (wdata_m[6:0] >= 7'd1 && wdata_m[6:0] <= `WSC_SEQ_MAX) begin
              seq_sel <= wdata_m[6:0];
              for (i = 0; i < 8; i = i + 1) begin
                mir[i] <= 32'h0000_0000;
              end
            end else begin
              s_axi_bresp <= 2'b10;
            end
          end
          `WSC_OFS_PAR_SEL: par_sel <= wdata_m[2:0];
          `WSC_OFS_SEQ_DATA: begin
            if (chk_err == 4'h0) begin
              sh_we <= 1'b1;
              sh_waddr <= {seq_sel, par_sel};
              sh_wdata <= wdata_m;
              mir[par_sel] <= wdata_m;
              last_data <= wdata_m;
              if (par_sel == 3'd5) dc_start_set[seq_sel] <= 1'b1;
              if (par_sel == 3'd6) dc_end_set[seq_sel] <= 1'b1;
            end else begin
              s_axi_bresp <= 2'b10;
              push_err <= 1'b1;
              push_code <= chk_err;
            end
          end
          `WSC_OFS_COMMAND: begin
            run_cmd <= wdata_m[`WSC_CMD_RUN];
            stop_cmd <= wdata_m[`WSC_CMD_STOP];
            pop_err <= wdata_m[`WSC_CMD_ERR_POP];
            xy_commit <= wdata_m[`WSC_CMD_XY_SUBMIT];
          end
          `WSC_OFS_XY_SEL: xy_sel <= wdata_m[XY_DEPTH_LOG2-1:0];
          `WSC_OFS_XY_DATA: begin
            // only with a u-i or i-u curve
            if (gen_type == `WSC_TYPE_XY_VOLT_VS_AMP ||
                gen_type == `WSC_TYPE_XY_AMP_VS_VOLT) begin
              xy_wr_en <= 1'b1;
              xy_wr_addr <= xy_sel;
              xy_wr_data <= wdata_m;
              xy_wr_is_amp <= gen_type == `WSC_TYPE_XY_AMP_VS_VOLT;
            end else begin
              s_axi_bresp <= 2'b10;
              push_err <= 1'b1;
              push_code <= `WSC_ERR_XY_NOSEL;
            end
          end
          `WSC_OFS_STATUS, `WSC_OFS_ERROR, `WSC_OFS_RUN_INFO: begin
          end
          default: s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end
  // ----------------------------------------
  // submit copy, shadow to active
  // ----------------------------------------
  wire submit_go = wr_go && aw_addr == `WSC_OFS_COMMAND && wdata_m[`WSC_CMD_SUBMIT];
  always @(posedge clk) begin
    copy_wr <= 1'b0;
    if (sys_rst) begin
      copy_busy <= 1'b0;
      copy_seq <= 7'd0;
      copy_par <= 3'd0;
      copy_waddr <= 10'd0;
      bank_valid <= 100'd0;
    end else if (submit_go && !copy_busy) begin
      copy_busy <= 1'b1;
      copy_seq <= 7'd1;
      copy_par <= 3'd0;
    end else if (copy_busy) begin
      // read data lags address by one cycle
      copy_wr <= 1'b1;
      copy_waddr <= {copy_seq, copy_par};
      {copy_seq, copy_par} <= {copy_seq, copy_par} + 10'd1;
      if (copy_waddr == {`WSC_SEQ_MAX, 3'd7}) begin
        copy_busy <= 1'b0;
        copy_wr <= 1'b0;
        bank_valid <= {100{1'b1}};
      end
    end
  end
  // ----------------------------------------
  // error queue, four deep
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      err_cnt <= 3'd0;
      err_rd <= 2'd0;
      for (i = 0; i < 4; i = i + 1) begin
        err_q[i] <= 4'h0;
      end
    end else begin
      // push wins when full queue is popped at once
      if (push_err && (err_cnt < 3'd4 || pop_err)) begin
        err_q[err_rd + err_cnt[1:0]] <= push_code;
      end
      if (pop_err && err_cnt != 3'd0) begin
        err_rd <= err_rd + 2'd1;
      end
      err_cnt <= err_cnt + {2'd0, push_err && (err_cnt < 3'd4 || pop_err)} -
        {2'd0, pop_err && err_cnt != 3'd0};
    end
  end
  // ----------------------------------------
  // run control
  // ----------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      arb_running <= 1'b0;
      xy_running <= 1'b0;
      act_seq <= `WSC_SEQ_RESET;
      cyc_done <= 10'd0;
      target_amp <= 1'b0;
      clip_negative <= 1'b0;
    end else begin
      target_amp <= gen_type == `WSC_TYPE_ARB_AMP;
      clip_negative <= (mir[5] < mir[0]) || (mir[6] < mir[1]);
      xy_running <= on_q && !alarm_q && !abort_q && !is_arb &&
        gen_type != `WSC_TYPE_NONE;
      if (stop_cmd || alarm_q || abort_q || !is_arb) begin
        arb_running <= 1'b0;
      end else if (run_cmd) begin
        arb_running <= 1'b1;
        act_seq <= seq_first;
        cyc_done <= 10'd0;
      end else if (arb_running && seq_done) begin
        if (act_seq < seq_last) begin
          act_seq <= act_seq + 7'd1;
        end else begin
          act_seq <= seq_first;
          if (cycles != 10'd0 && cyc_done + 10'd1 >= cycles) begin
            arb_running <= 1'b0;
          end else begin
            cyc_done <= cyc_done + 10'd1;
          end
        end
      end
    end
  end
  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `WSC_OFS_SELECT: s_axi_rdata <= {29'd0, gen_type};
        `WSC_OFS_SEQ_FIRST: s_axi_rdata <= {25'd0, seq_first};
        `WSC_OFS_SEQ_LAST: s_axi_rdata <= {25'd0, seq_last};
        `WSC_OFS_CYCLES: s_axi_rdata <= {22'd0, cycles};
        `WSC_OFS_SEQ_SEL: s_axi_rdata <= {25'd0, seq_sel};
        `WSC_OFS_PAR_SEL: s_axi_rdata <= {29'd0, par_sel};
        `WSC_OFS_SEQ_DATA: s_axi_rdata <= last_data;
        `WSC_OFS_COMMAND: s_axi_rdata <= 32'h0000_0000;
        `WSC_OFS_XY_SEL: s_axi_rdata <= {{(32-XY_DEPTH_LOG2){1'b0}}, xy_sel};
        `WSC_OFS_XY_DATA: s_axi_rdata <= xy_wr_data;
        `WSC_OFS_STATUS: s_axi_rdata <= {27'd0, copy_busy, clip_negative,
          target_amp, xy_running, arb_running};
        `WSC_OFS_ERROR: s_axi_rdata <= {25'd0, err_cnt,
          err_cnt != 3'd0 ? err_q[err_rd] : 4'h0};
        `WSC_OFS_RUN_INFO: s_axi_rdata <= {12'd0, cyc_done, 3'd0, act_seq};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### dv/wsc_core_checker.sv
// Purpose: port-level checks for wsc_core
// Assumes: one clock, sync active-high reset
// Notes: bound into every wsc_core instance
`timescale 1ns/1ps
`include "wsc_map.vh"
module wsc_core_checker #(
  parameter XY_DEPTH_LOG2 = 12
) (
  input wire clk,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire output_on,
  input wire alarm,
  input wire user_abort,
  input wire seq_done,
  input wire arb_running,
  input wire xy_running,
  input wire [6:0] act_seq
);
  // ----
  // bus and run checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_take;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence stop_cause;
    (alarm || user_abort) [*5];
  endsequence
  wr_resp_a: assert property (wr_both |-> ##[2:3] s_axi_bvalid)
    else $error("write response missing");
  b_done_a: assert property (b_take |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  excl_run_a: assert property (!(arb_running && xy_running))
    else $error("both generators running");
  seq_range_a: assert property (arb_running |-> act_seq >= 7'h1 && act_seq <= `WSC_SEQ_MAX)
    else $error("active sequence out of range");
  // sequence moves only when the engine ends one
  seq_step_a: assert property (arb_running && !seq_done |=> !arb_running || $stable(act_seq))
    else $error("sequence changed without end");
  xy_on_a: assert property ($rose(xy_running) |-> $past(output_on, 2))
    else $error("xy run without output on");
  xy_stop_a: assert property (stop_cause |-> !xy_running && !arb_running)
    else $error("run survived alarm or abort");
endmodule

bind wsc_core wsc_core_checker #(.XY_DEPTH_LOG2(XY_DEPTH_LOG2)) u_chk (.clk(clk),
  .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .output_on(output_on), .alarm(alarm), .user_abort(user_abort),
  .seq_done(seq_done), .arb_running(arb_running), .xy_running(xy_running), .act_seq(act_seq));

// ### dv/wsc_engine_model.sv
// Purpose: waveform engine stand-in ending each running sequence
// Assumes: same clock as the core
// Notes: slow mode gives random sequence lengths
`timescale 1ns/1ps
module wsc_engine_model (
  input wire clk,
  input wire sys_rst,
  input wire arb_running,
  input wire slow,
  output reg seq_done
);
  integer cnt;
  integer lim;
  always @(posedge clk) begin
    seq_done <= 1'b0;
    if (sys_rst || !arb_running) begin
      cnt <= 0;
      lim <= 2;
    end else if (cnt >= lim) begin
      seq_done <= 1'b1;
      cnt <= 0;
      lim <= slow ? 8 + $urandom % 24 : 2;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### dv/waveform_sequence_config_tb_top.sv
// Purpose: self-checking bench for wsc_core
// Assumes: one AXI4-Lite transfer at a time
// Notes: host pause after table submit is shortened
`timescale 1ns/1ps
`include "wsc_map.vh"
module waveform_sequence_config_tb_top;
  reg clk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, output_on = 1'b0, alarm = 1'b0, user_abort = 1'b0;
  reg slow = 1'b0, rd_chk = 1'b0;
  reg [7:0] awaddr = 8'h0, araddr = 8'h0;
  reg [31:0] wdata = 32'h0, rv, a, d, seed;
  reg [2:0] par_sel = 3'h0;
  wire awready, wready, bvalid, arready, rvalid, seq_done, arb_running, xy_running;
  wire target_amp, xy_wr_en, xy_wr_is_amp, xy_commit, clip;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, par_val, xy_wr_data;
  wire [6:0] act_seq;
  wire [11:0] xy_wr_addr;
  logic [63:0] exp_r[$], exp_seq[$], exp_xy[$];
  logic [1:0] exp_b[$];
  logic [41:0] tab [0:10];
  integer fails = 0, n_compared = 0, n_commit = 0, i, n;

  always #4 clk = ~clk;
  wsc_core u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .output_on(output_on),
    .alarm(alarm), .user_abort(user_abort), .seq_done(seq_done), .act_par_sel(par_sel),
    .act_par_value(par_val), .arb_running(arb_running), .xy_running(xy_running),
    .act_seq(act_seq), .target_amp(target_amp), .clip_negative(clip), .xy_wr_addr(xy_wr_addr),
    .xy_wr_data(xy_wr_data), .xy_wr_en(xy_wr_en), .xy_wr_is_amp(xy_wr_is_amp),
    .xy_commit(xy_commit));
  wsc_engine_model u_eng (.clk(clk), .sys_rst(sys_rst), .arb_running(arb_running),
    .slow(slow), .seq_done(seq_done));

  task cmp_word(input [63:0] e, input [63:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task cmp_resp(input [1:0] e, input [1:0] g);
    cmp_word({62'h0, e}, {62'h0, g});
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task hang;
    begin
      fails = fails + 1;
      print_verdict;
    end
  endtask
  // ----
  // bus master
  // ----
  task wr(input [7:0] ad, input [31:0] dt, input [1:0] r);
    begin
      @(posedge clk);
      exp_b.push_back(r);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (n > 50) hang;
      end while (!bvalid);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [31:0] e, input c);
    begin
      @(posedge clk);
      rd_chk = c;
      if (c) exp_r.push_back({32'h0, e});
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
        if (arvalid && arready) arvalid <= 1'b0;
        if (n > 50) hang;
      end while (!rvalid);
      rv = rdata;
      rready <= 1'b0;
    end
  endtask
  task cmd(input [31:0] c);
    wr(`WSC_OFS_COMMAND, c, 2'h0);
  endtask
  task wait_run(input v);
    for (n = 0; arb_running !== v; n = n + 1) begin
      if (n > 100) hang;
      @(posedge clk);
    end
  endtask
  task wait_seq;
    for (n = 0; exp_seq.size() > 0; n = n + 1) begin
      if (n > 5000) hang;
      @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    if (bvalid && bready) cmp_resp(exp_b.pop_front(), bresp);
    if (rvalid && rready && rd_chk) cmp_word(exp_r.pop_front(), {30'h0, rresp, rdata});
    if (xy_wr_en)
      cmp_word(exp_xy.pop_front(), {19'h0, xy_wr_is_amp, xy_wr_addr, xy_wr_data});
    if (seq_done && arb_running && exp_seq.size()) cmp_word(exp_seq.pop_front(), act_seq);
    if (xy_commit) n_commit = n_commit + 1;
  end

  initial begin
    tab = '{{8'h7, 32'h7d0, 2'h0}, {8'h0, 32'h1f4, 2'h2}, {8'h5, 32'h3e8, 2'h0},
      {8'h6, 32'h7d0, 2'h2}, {8'h6, 32'hbb8, 2'h0}, {8'h0, 32'h1f4, 2'h0},
      {8'h1, 32'h1f4, 2'h0}, {8'h2, 32'h1e, 2'h0}, {8'h3, 32'h14, 2'h2},
      {8'h3, 32'h5, 2'h0}, {8'h4, 32'h5a, 2'h0}};
    seed = $urandom(52);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`WSC_OFS_SEQ_FIRST, 32'h1, 1'b1);
    rd(`WSC_OFS_CYCLES, 32'h1, 1'b1);
    wr(`WSC_OFS_SEQ_FIRST, 32'h0, 2'h2);
    wr(`WSC_OFS_SEQ_LAST, 32'h64, 2'h2);
    wr(`WSC_OFS_SEQ_LAST, 32'h63, 2'h0);
    rd(`WSC_OFS_SEQ_LAST, 32'h63, 1'b1);
    rd(`WSC_OFS_ERROR, 32'h21, 1'b1);
    repeat (2) cmd(32'h10);
    $display("range test done");
    for (i = 0; i < 6; i = i + 1) begin
      wr(`WSC_OFS_SELECT, i, 2'h0);
      rd(`WSC_OFS_SELECT, i, 1'b1);
      if (i == 1 || i == 2) cmp_word(i == 2, target_amp);
    end
    wr(`WSC_OFS_XY_DATA, 32'h5, 2'h2);
    wr(`WSC_OFS_SELECT, 32'h1, 2'h0);
    wr(`WSC_OFS_XY_DATA, 32'h5, 2'h2);
    rd(`WSC_OFS_ERROR, 32'h22, 1'b1);
    repeat (2) cmd(32'h10);
    for (i = 3; i < 5; i = i + 1) begin
      a = $urandom;
      d = $urandom;
      wr(`WSC_OFS_SELECT, i, 2'h0);
      wr(`WSC_OFS_XY_SEL, {20'h0, a[11:0]}, 2'h0);
      exp_xy.push_back({19'h0, i == 4, a[11:0], d});
      wr(`WSC_OFS_XY_DATA, d, 2'h0);
    end
    cmd(32'h8);
    repeat (20) @(posedge clk); // shortened host pause
    cmp_word(64'h1, n_commit);
    cmp_word(64'h0, exp_xy.size());
    $display("select and table test done");
    wr(`WSC_OFS_SELECT, 32'h1, 2'h0);
    wr(`WSC_OFS_SEQ_FIRST, 32'h5, 2'h0);
    wr(`WSC_OFS_SEQ_LAST, 32'h5, 2'h0);
    wr(`WSC_OFS_SEQ_SEL, 32'h5, 2'h0);
    for (i = 0; i < 11; i = i + 1) begin
      wr(`WSC_OFS_PAR_SEL, {24'h0, tab[i][41:34]}, 2'h0);
      wr(`WSC_OFS_SEQ_DATA, tab[i][33:2], tab[i][1:0]);
    end
    rd(`WSC_OFS_SEQ_DATA, 32'h5a, 1'b1);
    rd(`WSC_OFS_SEQ_FIRST, 32'h5, 1'b1);
    rd(`WSC_OFS_ERROR, 32'h33, 1'b1);
    repeat (3) cmd(32'h10);
    wr(`WSC_OFS_CYCLES, 32'h0, 2'h0);
    par_sel <= 3'h5;
    cmd(32'h2);
    wait_run(1'b1);
    repeat (3) @(posedge clk);
    cmp_word(64'h0, par_val);
    cmd(32'h4);
    wait_run(1'b0);
    cmd(32'h1);
    for (i = 0; i == 0 || rv[4]; i = i + 1) begin
      if (i > 400) hang;
      rd(`WSC_OFS_STATUS, 32'h0, 1'b0);
    end
    cmd(32'h2);
    wait_run(1'b1);
    for (i = 0; i < 11; i = i + 1) if (tab[i][1:0] == 2'h0) begin
      par_sel <= tab[i][36:34];
      repeat (3) @(posedge clk);
      cmp_word({32'h0, tab[i][33:2]}, {32'h0, par_val});
    end
    cmd(32'h4);
    wait_run(1'b0);
    cmp_word(64'h0, clip);
    wr(`WSC_OFS_PAR_SEL, 32'h0, 2'h0);
    wr(`WSC_OFS_SEQ_DATA, 32'hfa0, 2'h0);
    repeat (2) @(posedge clk);
    cmp_word(64'h1, clip);
    $display("load and submit test done");
    wr(`WSC_OFS_SEQ_FIRST, 32'h3, 2'h0);
    wr(`WSC_OFS_CYCLES, 32'h2, 2'h0);
    slow <= 1'b1;
    for (i = 0; i < 6; i = i + 1) exp_seq.push_back(3 + i % 3);
    cmd(32'h2);
    wait_seq;
    repeat (5) @(posedge clk);
    cmp_word(64'h0, arb_running);
    wr(`WSC_OFS_CYCLES, 32'h0, 2'h0);
    slow <= 1'b0;
    for (i = 0; i < 7; i = i + 1) exp_seq.push_back(3 + i % 3);
    cmd(32'h2);
    wait_seq;
    cmp_word(64'h1, arb_running);
    cmd(32'h4);
    wait_run(1'b0);
    exp_seq.push_back(64'h3);
    cmd(32'h2);
    wait_seq;
    cmd(32'h4);
    $display("run order test done");
    wr(`WSC_OFS_SELECT, 32'h3, 2'h0);
    wr(`WSC_OFS_SEQ_DATA, 32'h1, 2'h2);
    for (i = 0; i < 2; i = i + 1) begin
      output_on <= 1'b1;
      repeat (8) @(posedge clk);
      cmp_word(64'h1, xy_running);
      alarm <= i == 0;
      user_abort <= i == 1;
      repeat (8) @(posedge clk);
      cmp_word(64'h0, xy_running);
      output_on <= 1'b0;
      alarm <= 1'b0;
      user_abort <= 1'b0;
      repeat (8) @(posedge clk);
    end
    wr(`WSC_OFS_SELECT, 32'h6, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    rd(`WSC_OFS_ERROR, 32'h15, 1'b1);
    $display("xy run test done");
    print_verdict;
  end
endmodule
